/* File: verilog/power_mode_control.sv */
// Low-power mode controller: idle, stop and suspend sequencing
//
// Summary of operation
// - Idle entered after setting instruction completes
// - Idle keeps registers and peripherals running
// - Interrupt or reset ends idle
// - Interrupt serviced, then resume after setter
// - Reset during idle restarts from vector
// - Enabled watchdog timeout resets out of idle
// - Stop halts oscillator, processor, digital peripherals
// - In stop only clock detector stays alive
// - Only reset leaves stop mode
// - Missing clock detector resets out of stop
// - Suspend halts processor and fast oscillator
// - Suspend keeps port match, and timer3 only when timer3_slow_clk is set
// - Three events end suspend
// - Suspend wake resumes after setter
// - Configured wake interrupt serviced after suspend
// - Idle and stop bits read zero
`timescale 1ns/1ps
module power_mode_control
  import pwr_pkg::*;
#(
  parameter int watchdog_cycles = watchdog_cycles_default
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Processor handshake
  input wire logic instr_done,
  input wire logic irq_pending,
  // Wake sources from pins
  input wire logic port_match,
  input wire logic timer3_ovf,
  input wire logic cmp_low,
  input wire logic timer3_slow_clk,
  // Gating outputs
  output logic cpu_run,
  output logic periph_run,
  output logic hfosc_run,
  output logic int_osc_run,
  output logic timer3_run,
  output logic port_match_run,
  output logic clock_detector_run,
  output logic irq_service,
  output logic soft_reset,
  output logic [3:0] mode_state
);

  // ******************************
  // Registers and wires
  // ******************************
  mode_e mode_r, mode_nxt;
  logic [5:0] gen_flags_r;
  logic [7:0] osc_r;
  logic [7:0] wake_cfg_r;
  logic idle_req_r, stop_req_r, susp_req_r;
  logic irq_svc_r;
  logic [3:0] wake_sync;
  wake_s wk;
  logic clock_detector_exp, watchdog_exp;
  logic wake_ev, susp_wake;
  logic watchdog_restart;
  bus_req_s req;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic hit(input bus_req_s r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction

  // ******************************
  // Synchronise external wake pins
  // ******************************
  sync2 #(.width(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({port_match, timer3_ovf, cmp_low, irq_pending}),
    .q(wake_sync)
  );
  assign wk = wake_s'(wake_sync);

  // ******************************
  // Watchdog and missing clock timers
  // ******************************
  assign watchdog_restart = req.wr && hit(req, wake_cfg_addr);

  timeout_cnt #(.limit(watchdog_cycles)) u_watchdog (
    .clk(clk),
    .reset(reset),
    .enable(wake_cfg_r[watchdog_en_bit] && mode_r == st_idle),
    .restart(watchdog_restart),
    .expired(watchdog_exp)
  );

  timeout_cnt #(.limit(clock_detector_cycles)) u_clock_detector (
    .clk(clk),
    .reset(reset),
    .enable(wake_cfg_r[clock_detector_en_bit] && mode_r == st_stop),
    .restart(1'b0),
    .expired(clock_detector_exp)
  );

  // ******************************
  // Register writes
  // ******************************
  always_ff @(posedge clk) begin
    if (reset) begin
      gen_flags_r <= power_control_rst[7:2];
      idle_req_r <= 1'b0;
      stop_req_r <= 1'b0;
    end else if (req.wr && hit(req, power_control_addr)) begin
      gen_flags_r <= wdata[7:2] & flags_mask_hi;
      stop_req_r <= wdata[stop_bit];
      idle_req_r <= wdata[idle_bit] && !wdata[stop_bit];
    end else if (mode_r == st_run && instr_done) begin
      idle_req_r <= 1'b0;
      stop_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_r <= internal_osc_rst;
      susp_req_r <= 1'b0;
    end else if (req.wr && hit(req, internal_osc_addr)) begin
      osc_r <= wdata;
      susp_req_r <= wdata[suspend_bit];
    end else if (mode_r == st_suspend && susp_wake) begin
      osc_r[suspend_bit] <= 1'b0;
    end else if (mode_r == st_run && instr_done) begin
      susp_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_cfg_r <= wake_cfg_rst;
    end else if (req.wr && hit(req, wake_cfg_addr)) begin
      wake_cfg_r <= wdata;
    end
  end

  // ******************************
  // Wake decode
  // ******************************
  assign wake_ev = wk.irq;
  assign susp_wake = wk.port_match || wk.timer3_ovf ||
    (wk.cmp_low && wake_cfg_r[cmp_wake_bit]);

  // ******************************
  // Mode sequencer
  // ******************************
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      st_run: begin
        if (instr_done && stop_req_r) begin
          mode_nxt = st_stop;
        end else if (instr_done && idle_req_r) begin
          mode_nxt = st_idle;
        end else if (instr_done && susp_req_r) begin
          mode_nxt = st_suspend;
        end
      end
      st_idle: begin
        if (wake_ev) begin
          mode_nxt = st_run;
        end
      end
      st_stop: begin
        mode_nxt = st_stop;
      end
      st_suspend: begin
        if (susp_wake) begin
          mode_nxt = st_run;
        end
      end
      default: begin
        mode_nxt = st_run;
      end
    endcase
    // Internal reset: mode_nxt returns to run, so gates and status follow
    if (soft_reset) begin
      mode_nxt = st_run;
    end
  end

  // Resets return to run; core restarts at its vector
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      mode_r <= st_run;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ******************************
  // Internal reset requests
  // ******************************
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= (watchdog_exp && mode_r == st_idle) ||
        (clock_detector_exp && mode_r == st_stop);
    end
  end

  // ******************************
  // Interrupt service after wake
  // ******************************
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_svc_r <= 1'b0;
    end else begin
      irq_svc_r <= (mode_r == st_idle && wake_ev) ||
        (mode_r == st_suspend && susp_wake && wk.irq);
    end
  end
  assign irq_service = irq_svc_r;

  // ******************************
  // Clock and block gating
  // ******************************
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_run <= 1'b1;
      periph_run <= 1'b1;
      hfosc_run <= 1'b1;
      int_osc_run <= 1'b1;
      timer3_run <= 1'b1;
      port_match_run <= 1'b1;
      clock_detector_run <= 1'b0;
    end else begin
      cpu_run <= mode_nxt == st_run;
      periph_run <= mode_nxt inside {st_run, st_idle};
      hfosc_run <= mode_nxt inside {st_run, st_idle};
      int_osc_run <= mode_nxt != st_stop;
      timer3_run <= mode_nxt inside {st_run, st_idle} ||
        (mode_nxt == st_suspend && timer3_slow_clk);
      port_match_run <= mode_nxt != st_stop;
      clock_detector_run <= wake_cfg_r[clock_detector_en_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_state <= st_run;
    end else begin
      mode_state <= mode_nxt;
    end
  end

  // ******************************
  // Register reads
  // ******************************
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (req.rd) begin
      if (hit(req, power_control_addr)) begin
        rdata <= {gen_flags_r, 2'b00};
      end else if (hit(req, internal_osc_addr)) begin
        rdata <= osc_r;
      end else if (hit(req, wake_cfg_addr)) begin
        rdata <= wake_cfg_r;
      end else if (hit(req, mode_status_addr)) begin
        rdata <= {4'h0, mode_r};
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end

  // ******************************
  // Assertions
  // ******************************
  property p_idle_entry;
    @(posedge clk) disable iff (reset || soft_reset)
      (mode_r == st_run && instr_done && idle_req_r && !stop_req_r)
      |=> mode_r == st_idle;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle not entered");

  property p_idle_wake;
    @(posedge clk) disable iff (reset || soft_reset)
      (mode_r == st_idle && wake_ev) |=> (mode_r == st_run && irq_svc_r);
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle wake failed");

  property p_stop_prio;
    @(posedge clk) disable iff (reset)
      (req.wr && hit(req, power_control_addr) && wdata[stop_bit])
      |=> !idle_req_r;
  endproperty
  a_stop_prio: assert property (p_stop_prio)
    else $error("idle set with stop");

  property p_stop_hold;
    @(posedge clk) disable iff (reset || soft_reset)
      (mode_r == st_stop && !reset && !soft_reset) |=> mode_r == st_stop;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop left without reset");

  property p_stop_gate;
    @(posedge clk) disable iff (reset)
      mode_r == st_stop |-> !cpu_run && !int_osc_run && !periph_run;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("stop gating wrong");

  property p_susp_wake;
    @(posedge clk) disable iff (reset || soft_reset)
      (mode_r == st_suspend && susp_wake) |=> ##[0:1] cpu_run;
  endproperty
  a_susp_wake: assert property (p_susp_wake)
    else $error("suspend wake failed");

  property p_susp_gate;
    @(posedge clk) disable iff (reset)
      mode_r == st_suspend |-> !cpu_run && !hfosc_run && port_match_run;
  endproperty
  a_susp_gate: assert property (p_susp_gate)
    else $error("suspend gating wrong");

  property p_read_zero;
    @(posedge clk) disable iff (reset)
      (req.rd && hit(req, power_control_addr)) |=> rdata[1:0] == 2'b00;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("mode bits read nonzero");

  property p_clock_detector_reset;
    @(posedge clk) disable iff (reset)
      (clock_detector_exp && mode_r == st_stop) |=>
        soft_reset ##1 mode_r == st_run;
  endproperty
  a_clock_detector_reset: assert property (p_clock_detector_reset)
    else $error("clock detector reset missing");

  c_idle: cover property (@(posedge clk) mode_r == st_idle ##1
    mode_r == st_run);
  c_stop: cover property (@(posedge clk) mode_r == st_stop);
  c_susp: cover property (@(posedge clk) mode_r == st_suspend ##1
    mode_r == st_run);
endmodule

/* File: pkg/pwr_pkg.sv */
// Constants and types shared by the power mode controller
package pwr_pkg;

  // ******************************
  // Register offsets
  // ******************************
  localparam logic [7:0] power_control_addr = 8'h87;
  localparam logic [7:0] internal_osc_addr = 8'hb2;
  localparam logic [7:0] wake_cfg_addr = 8'hc0;
  localparam logic [7:0] mode_status_addr = 8'hc1;

  // ******************************
  // Field positions
  // ******************************
  localparam int idle_bit = 0;
  localparam int stop_bit = 1;
  localparam int suspend_bit = 5;
  localparam int cmp_wake_bit = 0;
  localparam int clock_detector_en_bit = 1;
  localparam int watchdog_en_bit = 2;
  localparam logic [5:0] flags_mask_hi = 6'h3f;

  // ******************************
  // Reset values
  // ******************************
  localparam logic [7:0] power_control_rst = 8'h00;
  localparam logic [7:0] internal_osc_rst = 8'h00;
  localparam logic [7:0] wake_cfg_rst = 8'h06;

  // ******************************
  // Timing
  // ******************************
  localparam int clk_mhz = 200;
  localparam int clock_detector_timeout_us = 100;
  localparam int clock_detector_cycles = clock_detector_timeout_us * clk_mhz;
  localparam int watchdog_cycles_default = 65536;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [3:0] {
    st_run = 4'h1,
    st_idle = 4'h2,
    st_stop = 4'h4,
    st_suspend = 4'h8
  } mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic port_match;
    logic timer3_ovf;
    logic cmp_low;
    logic irq;
  } wake_s;

  typedef struct packed {
    logic cpu_run;
    logic periph_run;
    logic hfosc_run;
    logic int_osc_run;
  } gate_s;

endpackage

/* File: verilog/sync2.sv */
// Two-stage synchroniser for an external level
`timescale 1ns/1ps
module sync2 #(
  parameter int width = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: verilog/timeout_cnt.sv */
// Reloadable up-counter that pulses on expiry
`timescale 1ns/1ps
module timeout_cnt #(
  parameter int limit = 20000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic enable,
  input wire logic restart,
  output logic expired
);
  logic [31:0] count_r;

  always_ff @(posedge clk) begin
    if (reset || !enable || restart) begin
      count_r <= '0;
      expired <= 1'b0;
    end else if (count_r == 32'(limit - 1)) begin
      count_r <= '0;
      expired <= 1'b1;
    end else begin
      count_r <= count_r + 32'h1;
      expired <= 1'b0;
    end
  end
endmodule

/* File: tb/core_model.sv */
// Behavioural processor core that retires mode-setting writes
`timescale 1ns/1ps
module core_model
  import pwr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Observed bus and gate
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic cpu_run,
  // Handshake
  output logic instr_done
);
  // ******************************
  // Instruction retire
  // ******************************
  // Setter retires one cycle later; a halted core retires nothing
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= wr && cpu_run && (addr == power_control_addr ||
        addr == internal_osc_addr);
    end
  end
endmodule

/* File: tb/power_mode_control_test.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module power_mode_control_test;
  import pwr_pkg::*;
  localparam int watchdog_sim = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_pending = 1'b0;
  logic port_match = 1'b0;
  logic timer3_ovf = 1'b0;
  logic cmp_low = 1'b0;
  logic timer3_slow_clk = 1'b0;
  logic instr_done, cpu_run, periph_run, hfosc_run, int_osc_run;
  logic timer3_run, port_match_run, clock_detector_run;
  logic irq_service, soft_reset;
  logic [3:0] mode_state;
  logic svc;
  int mismatches = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  power_mode_control #(.watchdog_cycles(watchdog_sim)) i_power_mode_control (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .instr_done(instr_done),
    .irq_pending(irq_pending), .port_match(port_match),
    .timer3_ovf(timer3_ovf), .cmp_low(cmp_low),
    .timer3_slow_clk(timer3_slow_clk), .cpu_run(cpu_run),
    .periph_run(periph_run), .hfosc_run(hfosc_run),
    .int_osc_run(int_osc_run), .timer3_run(timer3_run),
    .port_match_run(port_match_run),
    .clock_detector_run(clock_detector_run),
    .irq_service(irq_service), .soft_reset(soft_reset),
    .mode_state(mode_state));

  core_model i_core_model (.clk(clk), .reset(reset), .addr(addr),
    .wr(wr), .cpu_run(cpu_run), .instr_done(instr_done));

  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_mode(input logic [3:0] m, input int n);
    svc = 1'b0;
    for (int i = 0; i < n && mode_state !== m; i++) begin
      @(posedge clk);
      #1 svc = svc | irq_service;
    end
    chk("mode_state", {4'h0, m}, {4'h0, mode_state});
  endtask

  task automatic wait_soft(input int n);
    for (int i = 0; i < n && soft_reset !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("soft_reset", 8'h01, {7'h00, soft_reset});
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset;
    chk("reset gates", 8'hfc, {cpu_run, periph_run, hfosc_run,
      int_osc_run, timer3_run, port_match_run, clock_detector_run,
      soft_reset});
    rd_reg(wake_cfg_addr, d);
    chk("wake_cfg", wake_cfg_rst, d);
    wr_reg(wake_cfg_addr, 8'h00);
    rd_reg(mode_status_addr, d);
    chk("mode_status", 8'h01, d);
    wr_reg(power_control_addr, 8'hfc);
    rd_reg(power_control_addr, d);
    chk("flags", 8'hfc, d);
    rd_reg(8'h10, d);
    chk("unmapped", 8'h00, d);
    $display("test reset done");
  endtask

  task automatic t_idle;
    wr_reg(power_control_addr, 8'h55);
    wait_mode(st_idle, 4);
    chk("idle gates", 8'h07, {4'h0, cpu_run, periph_run, hfosc_run,
      int_osc_run});
    @(posedge clk);
    irq_pending <= 1'b1;
    wait_mode(st_run, 6);
    chk("idle svc", 8'h01, {7'h00, svc});
    @(posedge clk);
    irq_pending <= 1'b0;
    rd_reg(power_control_addr, d);
    chk("idle bit", 8'h54, d);
    $display("test idle done");
  endtask

  task automatic t_stop;
    wr_reg(power_control_addr, 8'h03);
    wait_mode(st_stop, 4);
    chk("stop gates", 8'h00, {2'b00, cpu_run, periph_run, hfosc_run,
      int_osc_run, timer3_run, port_match_run});
    @(posedge clk);
    irq_pending <= 1'b1;
    port_match <= 1'b1;
    timer3_ovf <= 1'b1;
    repeat (8) @(posedge clk);
    irq_pending <= 1'b0;
    port_match <= 1'b0;
    timer3_ovf <= 1'b0;
    #1 chk("stop held", {4'h0, st_stop}, {4'h0, mode_state});
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("stop reset", {4'h0, st_run}, {4'h0, mode_state});
    wr_reg(wake_cfg_addr, 8'h00);
    rd_reg(power_control_addr, d);
    chk("stop bit", 8'h00, d);
    $display("test stop done");
  endtask

  task automatic t_suspend;
    logic [2:0] src;
    wr_reg(wake_cfg_addr, 8'h01);
    for (int i = 0; i < 3; i++) begin
      src = 3'b100 >> i;
      timer3_slow_clk <= (i == 1);
      wr_reg(internal_osc_addr, 8'h20);
      wait_mode(st_suspend, 4);
      chk("susp gates", {6'h00, 1'b1, i == 1}, {cpu_run, hfosc_run,
        4'h0, port_match_run, timer3_run});
      @(posedge clk);
      {port_match, timer3_ovf, cmp_low} <= src;
      irq_pending <= (i == 0);
      wait_mode(st_run, 6);
      chk("susp svc", {7'h00, i == 0}, {7'h00, svc});
      @(posedge clk);
      {port_match, timer3_ovf, cmp_low} <= 3'b000;
      irq_pending <= 1'b0;
      rd_reg(internal_osc_addr, d);
      chk("suspend bit", 8'h00, d & 8'h20);
      repeat (3) @(posedge clk);
    end
    $display("test suspend done");
  endtask

  task automatic t_watchdog;
    wr_reg(wake_cfg_addr, 8'h04);
    wr_reg(power_control_addr, 8'h01);
    wait_mode(st_idle, 4);
    wait_soft(watchdog_sim + 8);
    wait_mode(st_run, 4);
    wr_reg(wake_cfg_addr, 8'h00);
    $display("test watchdog done");
  endtask

  task automatic t_clock_detector;
    wr_reg(wake_cfg_addr, 8'h02);
    @(posedge clk);
    #1 chk("detector_run", 8'h01, {7'h00, clock_detector_run});
    wr_reg(power_control_addr, 8'h02);
    wait_mode(st_stop, 4);
    wait_soft(clock_detector_cycles + 10);
    wait_mode(st_run, 4);
    wr_reg(wake_cfg_addr, 8'h00);
    $display("test clock detector done");
  endtask

  // ******************************
  // Sequence and watchdog
  // ******************************
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset;
    t_idle;
    t_stop;
    t_suspend;
    t_watchdog;
    t_clock_detector;
    end_of_test;
  end

  initial begin
    #300000;
    mismatches++;
    end_of_test;
  end
endmodule
